/* File: hw/lle_pkg.sv */
// Package: offsets, codes and reset values for the loop and error monitor
package lle_pkg;
   localparam logic [7:0] OFF_LOOP    = 8'h00;
   localparam logic [7:0] OFF_CMD     = 8'h04;
   localparam logic [7:0] OFF_BLKERR  = 8'h08;
   localparam logic [7:0] OFF_BERSEL  = 8'h0C;
   localparam logic [7:0] OFF_BERLO   = 8'h10;
   localparam logic [7:0] OFF_BERHI   = 8'h14;
   localparam logic [7:0] OFF_STATUS  = 8'h18;
   // Loop control fields
   localparam int LOOP_B1   = 0;
   localparam int LOOP_B2   = 1;
   localparam int LOOP_ALL  = 2;
   localparam int LOOP_DIR  = 3;
   localparam int LOOP_PASS = 4;
   localparam int LOOP_FRM  = 5;
   localparam logic [5:0] LOOP_RST = 6'h00;
   // Command codes
   localparam logic [3:0] CMD_DR  = 4'h0;
   localparam logic [3:0] CMD_AR  = 4'h8;
   localparam logic [3:0] CMD_AR1 = 4'h9;
   localparam logic [3:0] CMD_AR2 = 4'hA;
   localparam logic [3:0] CMD_AR4 = 4'hB;
   localparam logic [3:0] CMD_RST = 4'h0;
   // Channel identifiers
   localparam logic [1:0] CH_B1 = 2'h0;
   localparam logic [1:0] CH_B2 = 2'h1;
   localparam logic [1:0] CH_D  = 2'h2;
   // Bit error channel select
   localparam logic [1:0] BSEL_OFF = 2'h0;
   localparam logic [1:0] BSEL_B1  = 2'h1;
   localparam logic [1:0] BSEL_B2  = 2'h2;
   localparam logic [1:0] BSEL_ALL = 2'h3;
   // Activation states reported by the state machine
   localparam logic [2:0] ST_DEACT  = 3'h0;
   localparam logic [2:0] ST_SYNNT  = 3'h3;
   localparam logic [2:0] ST_LINKTE = 3'h4;
   localparam logic [2:0] ST_WAIT1  = 3'h5;
   localparam logic [2:0] ST_TRANSP = 3'h6;
   // Repeater request pattern length in frames
   localparam logic [3:0] REP_FRAMES = 4'h8;
   typedef enum logic [1:0] {M_ZERO, M_PLUS, M_ALT} lle_mmode_t;
endpackage

/* File: hw/lle_sat_counter.sv */
// Saturating event counter with clear-on-read and hold-clear
`timescale 1ns/1ns
module lle_sat_counter #(
   parameter int W = 8
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [1:0]   incAmt,
   input  wire logic         readClr,
   input  wire logic         holdClr,
   output logic [W-1:0]      count
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic [W:0]   sum;
   wire  [W-1:0] base = readClr ? '0 : count_reg;

   // An event in a read-clear cycle is kept, it lands on a zero base
   assign sum = {1'b0, base} + {{(W-1){1'b0}}, incAmt};
   assign count_next = holdClr ? '0 : (sum[W] ? {W{1'b1}} : sum[W-1:0]);
   assign count = count_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule

/* File: hw/lle_mchan_gen.sv */
// M-channel symbol generator for remote loop requests
`timescale 1ns/1ns
module lle_mchan_gen (
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              frameStrobe,
   input  wire logic              start,
   input  lle_pkg::lle_mmode_t    mode,
   output logic                   mTxPlus
);
   logic [3:0] left_reg;
   logic [3:0] left_next;
   logic       sym_reg;
   logic       sym_next;
   wire        altRun = left_reg != 4'h0;

   assign left_next = start ? lle_pkg::REP_FRAMES
                    : (frameStrobe && altRun) ? left_reg - 4'h1 : left_reg;

   always_comb begin
      sym_next = sym_reg;
      if (frameStrobe) begin
         unique case (mode)
            lle_pkg::M_PLUS: sym_next = 1'b1;
            lle_pkg::M_ALT:  sym_next = altRun ? ~left_reg[0] : 1'b0;
            lle_pkg::M_ZERO: sym_next = 1'b0;
         endcase
      end
   end
   assign mTxPlus = sym_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         left_reg <= 4'h0;
         sym_reg  <= 1'b0;
      end else begin
         left_reg <= left_next;
         sym_reg  <= sym_next;
      end
   end
endmodule

/* File: hw/lle_line_loop_monitor.sv */
// Line loop control, block error and bit error counting for one line port
`timescale 1ns/1ns
module lle_line_loop_monitor #(
   parameter int BLK_W = 8,
   parameter int BER_W = 16
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   // APB slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Frame events from the deframer
   input  wire logic         frameStrobe,
   input  wire logic         frameCodeViol,
   input  wire logic         mRxPlus,
   input  wire logic [2:0]   actState,
   // Monitor channel read of the block error count
   input  wire logic         monRead,
   output logic [7:0]        monData,
   // Bit streams, shared channel tag
   input  wire logic         bitValid,
   input  wire logic [1:0]   chan,
   input  wire logic         sysTxBit,
   input  wire logic         lineRxBit,
   output logic              lineTxValid,
   output logic              lineTxBit,
   output logic              sysRxValid,
   output logic              sysRxBit,
   // Loop and activation controls toward the line circuits
   output logic              analogLoopEn,
   output logic              mTxPlus,
   output logic              activationInhibit
);
   logic [5:0]       loop_reg;
   logic [5:0]       loop_next;
   logic [3:0]       cmd_reg;
   logic [3:0]       cmd_next;
   logic [1:0]       berSel_reg;
   logic [1:0]       berSel_next;
   logic             inhibit_reg;
   logic             inhibit_next;
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;
   logic             err_reg;
   logic             err_next;
   logic             rdy_reg;
   logic             rdy_next;
   logic             ltxV_reg;
   logic             ltxB_reg;
   logic             srxV_reg;
   logic             srxB_reg;
   logic             ltxB_next;
   logic             srxB_next;
   logic [7:0]       mon_reg;
   logic [7:0]       mon_next;
   logic [BLK_W-1:0] blkCount;
   logic [BER_W-1:0] berCount;
   lle_pkg::lle_mmode_t mMode;

   // Bus decode
   // One wait state: read data is registered at the same edge where pready rises
   wire access   = psel && penable;
   wire accFirst = access && !rdy_reg;
   wire wrEn     = access && pwrite && rdy_reg;
   wire rdEn     = accFirst && !pwrite;
   wire hitLoop = paddr == lle_pkg::OFF_LOOP;
   wire hitCmd  = paddr == lle_pkg::OFF_CMD;
   wire hitBlk  = paddr == lle_pkg::OFF_BLKERR;
   wire hitSel  = paddr == lle_pkg::OFF_BERSEL;
   wire hitLo   = paddr == lle_pkg::OFF_BERLO;
   wire hitHi   = paddr == lle_pkg::OFF_BERHI;
   wire hitSt   = paddr == lle_pkg::OFF_STATUS;
   wire mapped  = hitLoop | hitCmd | hitBlk | hitSel | hitLo | hitHi | hitSt;
   wire cmdWr   = wrEn && hitCmd;

   // Loop control fields
   wire b1Loop    = loop_reg[lle_pkg::LOOP_B1];
   wire b2Loop    = loop_reg[lle_pkg::LOOP_B2];
   wire allLoop   = loop_reg[lle_pkg::LOOP_ALL];
   wire dirLine   = loop_reg[lle_pkg::LOOP_DIR];
   wire passThru  = loop_reg[lle_pkg::LOOP_PASS];
   wire framerLp  = loop_reg[lle_pkg::LOOP_FRM];

   // Commanded loops
   wire analogReq = cmd_reg == lle_pkg::CMD_AR1;
   wire remoteReq = cmd_reg == lle_pkg::CMD_AR2;
   wire repReq    = cmd_reg == lle_pkg::CMD_AR4;
   wire wholeLoop = analogReq || framerLp;

   // Channel match for local loops
   wire isB1   = chan == lle_pkg::CH_B1;
   wire isB2   = chan == lle_pkg::CH_B2;
   wire locSel = allLoop || (b1Loop && isB1) || (b2Loop && isB2);
   wire toSys  = locSel && !dirLine;
   wire toLine = locSel && dirLine;

   // Receive side toward the system
   always_comb begin
      if (wholeLoop) begin
         srxB_next = sysTxBit;
      end else if (toSys) begin
         srxB_next = sysTxBit;
      end else if (toLine && !passThru) begin
         srxB_next = 1'b1;
      end else begin
         srxB_next = lineRxBit;
      end
   end

   // Transmit side toward the line; the whole-channel loops stay transparent
   always_comb begin
      if (wholeLoop) begin
         ltxB_next = sysTxBit;
      end else if (toLine) begin
         ltxB_next = lineRxBit;
      end else if (toSys && !passThru) begin
         ltxB_next = 1'b1;
      end else begin
         ltxB_next = sysTxBit;
      end
   end

   // M-channel request; only the repeater and far-end loops are remote
   always_comb begin
      if (remoteReq) begin
         mMode = lle_pkg::M_PLUS;
      end else if (repReq) begin
         mMode = lle_pkg::M_ALT;
      end else begin
         mMode = lle_pkg::M_ZERO;
      end
   end

   lle_mchan_gen u_mgen (
      .mclk        (mclk),
      .resetn      (resetn),
      .frameStrobe (frameStrobe),
      .start       (cmdWr && pwdata[3:0] == lle_pkg::CMD_AR4),
      .mode        (mMode),
      .mTxPlus     (mTxPlus)
   );

   // Block error counting
   wire countState = actState == lle_pkg::ST_SYNNT
                  || actState == lle_pkg::ST_LINKTE
                  || actState == lle_pkg::ST_WAIT1
                  || actState == lle_pkg::ST_TRANSP;
   wire nearErr = frameStrobe && frameCodeViol;
   wire farErr  = frameStrobe && mRxPlus;
   wire [1:0] blkInc = {1'b0, nearErr} + {1'b0, farErr};
   wire blkRead = monRead || (rdEn && hitBlk);

   lle_sat_counter #(.W(BLK_W)) u_blk (
      .mclk    (mclk),
      .resetn  (resetn),
      .incAmt  (blkInc),
      .readClr (blkRead),
      .holdClr (!countState),
      .count   (blkCount)
   );

   // Bit error tally; results mean something only with the far-end loop closed
   wire berChOk = (berSel_reg == lle_pkg::BSEL_ALL)
               || (berSel_reg == lle_pkg::BSEL_B1 && isB1)
               || (berSel_reg == lle_pkg::BSEL_B2 && isB2);
   wire berHit  = berSel_reg != lle_pkg::BSEL_OFF && bitValid && berChOk
               && lineRxBit;

   lle_sat_counter #(.W(BER_W)) u_ber (
      .mclk    (mclk),
      .resetn  (resetn),
      .incAmt  ({1'b0, berHit}),
      .readClr (rdEn && hitLo),
      .holdClr (1'b0),
      .count   (berCount)
   );

   // Register writes
   assign loop_next   = (wrEn && hitLoop) ? pwdata[5:0] : loop_reg;
   assign cmd_next    = cmdWr ? pwdata[3:0] : cmd_reg;
   assign berSel_next = (wrEn && hitSel) ? pwdata[1:0] : berSel_reg;

   // A framer loop closed while deactivated blocks activation until opened
   assign inhibit_next = !framerLp ? 1'b0
                       : (actState == lle_pkg::ST_DEACT) ? 1'b1 : inhibit_reg;

   // Read data; unmapped addresses answer zero with an error
   wire [31:0] statusWord = {24'h0, inhibit_reg, framerLp, analogReq,
                             remoteReq, repReq, actState};
   always_comb begin
      rdata_next = 32'h0;
      if (rdEn) begin
         if (hitLoop) begin
            rdata_next = {26'h0, loop_reg};
         end else if (hitCmd) begin
            rdata_next = {28'h0, cmd_reg};
         end else if (hitBlk) begin
            rdata_next = {{(32-BLK_W){1'b0}}, blkCount};
         end else if (hitSel) begin
            rdata_next = {30'h0, berSel_reg};
         end else if (hitLo) begin
            rdata_next = {24'h0, berCount[7:0]};
         end else if (hitHi) begin
            rdata_next = {24'h0, berCount[15:8]};
         end else if (hitSt) begin
            rdata_next = statusWord;
         end
      end
   end
   assign err_next = accFirst && !mapped;
   assign rdy_next = accFirst;
   assign mon_next = monRead ? blkCount[7:0] : mon_reg;

   // Access completes in its second cycle, with data and error from flip-flops
   assign pready            = rdy_reg;
   assign prdata            = rdata_reg;
   assign pslverr           = err_reg;
   assign monData           = mon_reg;
   assign lineTxValid       = ltxV_reg;
   assign lineTxBit         = ltxB_reg;
   assign sysRxValid        = srxV_reg;
   assign sysRxBit          = srxB_reg;
   assign analogLoopEn      = analogReq;
   assign activationInhibit = inhibit_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         loop_reg    <= lle_pkg::LOOP_RST;
         cmd_reg     <= lle_pkg::CMD_RST;
         berSel_reg  <= lle_pkg::BSEL_OFF;
         inhibit_reg <= 1'b0;
         err_reg     <= 1'b0;
         rdy_reg     <= 1'b0;
         mon_reg     <= 8'h00;
      end else begin
         loop_reg    <= loop_next;
         cmd_reg     <= cmd_next;
         berSel_reg  <= berSel_next;
         inhibit_reg <= inhibit_next;
         err_reg     <= err_next;
         rdy_reg     <= rdy_next;
         mon_reg     <= mon_next;
      end
   end

   // Read data is captured in the access cycle and held until the next read
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 32'h0;
      end else if (rdEn) begin
         rdata_reg <= rdata_next;
      end
   end

   // One cycle of latency on both data paths
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ltxV_reg <= 1'b0;
         ltxB_reg <= 1'b1;
         srxV_reg <= 1'b0;
         srxB_reg <= 1'b1;
      end else begin
         ltxV_reg <= bitValid;
         ltxB_reg <= ltxB_next;
         srxV_reg <= bitValid;
         srxB_reg <= srxB_next;
      end
   end
endmodule

/* File: testbench/lle_line_loop_monitor_props.sv */
// Checker for the line loop monitor ports
`timescale 1ns/1ns
module lle_line_loop_monitor_props #(
   parameter int BLK_W = 8,
   parameter int BER_W = 16
) (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        frameStrobe,
   input wire logic [2:0]  actState,
   input wire logic        monRead,
   input wire logic [7:0]  monData,
   input wire logic        bitValid,
   input wire logic        sysTxBit,
   input wire logic        sysRxBit,
   input wire logic        lineTxBit,
   input wire logic        analogLoopEn,
   input wire logic        mTxPlus,
   input wire logic        activationInhibit
);
   logic [3:0] cmdSeen;
   logic [5:0] loopSeen;
   wire        wrAcc = psel && penable && pwrite && pready;
   wire        cmdWr = wrAcc && (paddr == lle_pkg::OFF_CMD);
   wire        act   = (actState >= lle_pkg::ST_SYNNT) && (actState <= lle_pkg::ST_TRANSP);
   // Shadows rebuilt from bus traffic, since the checker sees no internals
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cmdSeen  <= lle_pkg::CMD_RST;
         loopSeen <= lle_pkg::LOOP_RST;
      end else begin
         if (cmdWr) begin
            cmdSeen <= pwdata[3:0];
         end
         if (wrAcc && (paddr == lle_pkg::OFF_LOOP)) begin
            loopSeen <= pwdata[5:0];
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_analog_cmd:
      assert property (analogLoopEn == (cmdSeen == lle_pkg::CMD_AR1))
      else $error("analog loop not tied to command");
   a_mtx_hold:
      assert property (!frameStrobe |=> $stable(mTxPlus))
      else $error("M symbol moved between frames");
   a_mtx_remote:
      assert property (frameStrobe && !cmdWr && cmdSeen == lle_pkg::CMD_AR2 |=> mTxPlus)
      else $error("remote request not sent as plus");
   a_mtx_idle:
      assert property (frameStrobe && !cmdWr && (cmdSeen == lle_pkg::CMD_DR
         || cmdSeen == lle_pkg::CMD_AR) |=> !mTxPlus)
      else $error("idle M symbol not zero");
   a_blk_inactive:
      assert property (!act ##1 (!act && monRead) |=> monData == 8'h00)
      else $error("block count not held clear");
   a_mon_clear:
      assert property ((monRead && !frameStrobe) [*2] |=> monData == 8'h00)
      else $error("block count not cleared by read");
   a_frm_transp:
      assert property (bitValid && loopSeen[lle_pkg::LOOP_FRM] |=>
         sysRxBit == $past(sysTxBit) && lineTxBit == $past(sysTxBit))
      else $error("framer loop not transparent");
   a_inhibit_set:
      assert property (loopSeen[lle_pkg::LOOP_FRM] && actState == lle_pkg::ST_DEACT
         |=> activationInhibit)
      else $error("activation not inhibited");
endmodule

bind lle_line_loop_monitor lle_line_loop_monitor_props #(.BLK_W(BLK_W), .BER_W(BER_W)) uProps (
   .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .paddr(paddr), .pwdata(pwdata), .frameStrobe(frameStrobe), .actState(actState),
   .monRead(monRead), .monData(monData), .bitValid(bitValid), .sysTxBit(sysTxBit),
   .sysRxBit(sysRxBit), .lineTxBit(lineTxBit), .analogLoopEn(analogLoopEn),
   .mTxPlus(mTxPlus), .activationInhibit(activationInhibit));

/* File: testbench/lle_far_end_model.sv */
// Far-end terminal model: remote loop state and far-end error echo
`timescale 1ns/1ns
module lle_far_end_model (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic frameStrobe,
   input  wire logic mTxPlus,
   input  wire logic violSeen,
   output logic      mRxPlus,
   output logic      loopClosed
);
   logic [3:0] plusRun;
   logic [3:0] zeroRun;
   // Runs stop at 8 so a long request cannot wrap
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mRxPlus    <= 1'h0;
         loopClosed <= 1'h0;
         plusRun    <= 4'h0;
         zeroRun    <= 4'h0;
      end else if (frameStrobe) begin
         mRxPlus <= violSeen;
         plusRun <= mTxPlus ? plusRun + {3'h0, plusRun != 4'h8} : 4'h0;
         zeroRun <= mTxPlus ? 4'h0 : zeroRun + {3'h0, zeroRun != 4'h8};
         if (mTxPlus && plusRun == 4'h7) loopClosed <= 1'h1;
         if (!mTxPlus && zeroRun == 4'h7) loopClosed <= 1'h0;
      end
   end
endmodule

/* File: testbench/test_line_loopback_error_monitor.sv */
// Bench for the line loop and error monitor
`timescale 1ns/1ns
module test_line_loopback_error_monitor;
   logic        mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        frameStrobe = 1'h0, frameCodeViol = 1'h0, farViol = 1'h0, monRead = 1'h0;
   logic        bitValid = 1'h0, sysTxBit = 1'h0, lineRxBit = 1'h0, errSeen;
   logic        pready, pslverr, mRxPlus, loopClosed, lineTxValid, lineTxBit, sysRxValid;
   logic        sysRxBit, analogLoopEn, mTxPlus, inhibit;
   logic [7:0]  paddr = 8'h00, monData, hiByte;
   logic [31:0] pwdata = 32'h0, prdata, rd, rnd;
   logic [2:0]  actState = 3'h0;
   logic [1:0]  chan = 2'h0, sel, c, expOut;
   logic [5:0]  cfg;
   logic [3:0]  cmd;
   logic [3:0]  cmds [6] = '{lle_pkg::CMD_AR4, lle_pkg::CMD_AR2, lle_pkg::CMD_AR,
                             lle_pkg::CMD_AR2, lle_pkg::CMD_DR, lle_pkg::CMD_AR1};
   logic [5:0]  cfgs [7] = '{6'h00, 6'h01, 6'h12, 6'h0C, 6'h1B, 6'h20, 6'h06};
   integer      miscompares = 0, checks = 0, seed = 32'h6dd3, blk = 0, ber = 0, prevFar = 0;
   always #2 mclk = ~mclk;
   lle_line_loop_monitor dut (
      .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frameStrobe(frameStrobe), .frameCodeViol(frameCodeViol), .mRxPlus(mRxPlus),
      .actState(actState), .monRead(monRead), .monData(monData), .bitValid(bitValid),
      .chan(chan), .sysTxBit(sysTxBit), .lineRxBit(lineRxBit), .lineTxValid(lineTxValid),
      .lineTxBit(lineTxBit), .sysRxValid(sysRxValid), .sysRxBit(sysRxBit),
      .analogLoopEn(analogLoopEn), .mTxPlus(mTxPlus), .activationInhibit(inhibit));
   lle_far_end_model uFar (.mclk(mclk), .resetn(resetn), .frameStrobe(frameStrobe),
      .mTxPlus(mTxPlus), .violSeen(farViol), .mRxPlus(mRxPlus), .loopClosed(loopClosed));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Holds the request until pready; read data and error are taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      @(posedge mclk);
      while (pready !== 1'h1) @(posedge mclk);
      errSeen = pslverr;
      rd      = prdata;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(negedge mclk);
   endtask
   task automatic frame(input logic cv, input logic far, input logic expM);
      @(posedge mclk);
      frameStrobe   <= 1'h1;
      frameCodeViol <= cv;
      farViol       <= far;
      @(posedge mclk);
      frameStrobe <= 1'h0;
      if (actState < lle_pkg::ST_SYNNT || actState > lle_pkg::ST_TRANSP) blk = 0;
      else blk = (blk + cv + prevFar > 255) ? 255 : blk + cv + prevFar;
      prevFar = far;
      @(negedge mclk);
      chk(mTxPlus, expM);
   endtask
   task automatic monPulse;
      @(posedge mclk);
      monRead <= 1'h1;
      @(posedge mclk);
      @(negedge mclk);
      chk(monData, blk);
      @(posedge mclk);
      monRead <= 1'h0;
      @(negedge mclk);
      chk(monData, 32'h0);
      blk = 0;
   endtask
   function automatic logic [1:0] loopExp(input logic [1:0] ch, input logic s, input logic l);
      logic cov;
      cov = cfg[2] || (cfg[0] && ch == 2'h0) || (cfg[1] && ch == 2'h1);
      if (cmd == lle_pkg::CMD_AR1 || cfg[5]) return {s, s};
      if (cov && !cfg[3]) return {s, cfg[4] ? s : 1'h1};
      if (cov) return {cfg[4] ? l : 1'h1, l};
      return {l, s};
   endfunction
   task automatic stream(input int n);
      logic [31:0] r;
      for (int k = 0; k <= n; k++) begin
         r = $random(seed);
         c = r[1:0] % 2'h3;
         @(posedge mclk);
         bitValid  <= (k < n);
         chan      <= c;
         sysTxBit  <= r[2];
         lineRxBit <= r[3];
         @(negedge mclk);
         if (k > 0) chk({sysRxValid, lineTxValid, sysRxBit, lineTxBit}, {2'h3, expOut});
         expOut = loopExp(c, r[2], r[3]);
         if (k < n && r[3] && sel != 2'h0 && (sel == 2'h3 || sel == c + 2'h1)) ber++;
      end
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      final_report;
   end
   initial begin
      repeat (2) @(posedge mclk);
      resetn <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         apb(1'h0, 8'(i * 4), 32'h0);
         chk(rd, 32'h0);
         chk(errSeen, i == 7);
      end
      foreach (cmds[n]) begin
         cmd = cmds[n];
         apb(1'h1, lle_pkg::OFF_CMD, {28'h0, cmd});
         chk(analogLoopEn, cmd == lle_pkg::CMD_AR1);
         for (int j = 0; j < 10; j++) begin
            frame(1'h0, 1'h0, cmd == lle_pkg::CMD_AR2 || (cmd == lle_pkg::CMD_AR4 && j < 8 && j % 2 == 0));
         end
         chk(loopClosed, cmd == lle_pkg::CMD_AR2);
      end
      @(posedge mclk);
      actState <= lle_pkg::ST_SYNNT;
      for (int j = 0; j < 130; j++) frame(1'h1, 1'h1, 1'h0);
      apb(1'h0, lle_pkg::OFF_BLKERR, 32'h0);
      chk(rd, blk);
      blk = 0;
      apb(1'h0, lle_pkg::OFF_BLKERR, 32'h0);
      chk(rd, blk);
      for (int j = 0; j < 24; j++) begin
         rnd = $random(seed);
         frame(rnd[0], rnd[1], 1'h0);
      end
      monPulse;
      @(posedge mclk);
      actState <= lle_pkg::ST_DEACT;
      frame(1'h1, 1'h1, 1'h0);
      frame(1'h1, 1'h0, 1'h0);
      monPulse;
      foreach (cfgs[n]) begin
         cfg = cfgs[n];
         cmd = (n == 0) ? lle_pkg::CMD_AR1 : lle_pkg::CMD_DR;
         sel = n[1:0];
         apb(1'h1, lle_pkg::OFF_CMD, {28'h0, cmd});
         apb(1'h1, lle_pkg::OFF_LOOP, {26'h0, cfg});
         apb(1'h1, lle_pkg::OFF_BERSEL, {30'h0, sel});
         chk(inhibit, cfg[5]);
         apb(1'h0, lle_pkg::OFF_STATUS, 32'h0);
         chk(rd, {24'h0, cfg[5], cfg[5], cmd == lle_pkg::CMD_AR1, 2'h0, lle_pkg::ST_DEACT});
         stream(40);
         sel = lle_pkg::BSEL_OFF;
         apb(1'h1, lle_pkg::OFF_BERSEL, 32'h0);
         stream(8);
         apb(1'h0, lle_pkg::OFF_BERHI, 32'h0);
         hiByte = rd[7:0];
         apb(1'h0, lle_pkg::OFF_BERLO, 32'h0);
         chk({hiByte, rd[7:0]}, ber);
         ber = 0;
      end
      final_report;
   end
endmodule
